// ### src/oraret_pkg.sv
// Purpose: Shared constants and types for the OR and return instruction execution block.
// Assumes: 8-bit data, 13-bit program counter, 8-level hardware stack.
// Notes:   Opcode codes are local to this block's decoded-operation port.
package oraret_pkg;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 13;
    localparam int STACK_D = 8;
    localparam int SP_W    = 3;
    localparam int OP_W    = 4;

    localparam logic [OP_W-1:0] OP_NOP      = 4'h0;
    localparam logic [OP_W-1:0] OP_OR_AM    = 4'h1;
    localparam logic [OP_W-1:0] OP_OR_AX    = 4'h2;
    localparam logic [OP_W-1:0] OP_ORM      = 4'h3;
    localparam logic [OP_W-1:0] OP_RET      = 4'h4;
    localparam logic [OP_W-1:0] OP_RET_AX   = 4'h5;
    localparam logic [OP_W-1:0] OP_INTERRUPT_EXIT_INSTR     = 4'h6;
    localparam logic [OP_W-1:0] OP_CALL     = 4'h7;

    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
    localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
    localparam logic [PC_W-1:0]   INT_VECTOR = 13'h0004;
    localparam logic [SP_W-1:0]   SP_ONE    = 3'h1;
    localparam logic [SP_W-1:0]   SP_RESET  = 3'h0;

    typedef enum logic [2:0] {
        ORAR_IDLE = 3'b001,
        ORAR_EXEC = 3'b010,
        ORAR_WAIT = 3'b100
    } oraret_state_t;
endpackage

// ### src/oraret_stack.sv
// Purpose: Hardware return-address stack memory.
// Assumes: At most one write per cycle and one read every cycle; read data is registered.
// Notes:   Stack pointer is kept by the caller.
`timescale 1ns/10ps
`default_nettype none
module oraret_stack (
    // Clock.
    input  wire logic                         clk,
    // Write side.
    input  wire logic                         wr_en,
    input  wire logic [oraret_pkg::SP_W-1:0]  wr_addr,
    input  wire logic [oraret_pkg::PC_W-1:0]  wr_data,
    // Read side.
    input  wire logic [oraret_pkg::SP_W-1:0]  rd_addr,
    output var  logic [oraret_pkg::PC_W-1:0]  rd_data
);
    import oraret_pkg::*;

    logic [PC_W-1:0] mem [STACK_D];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // oraret_stack
`default_nettype wire

// ### src/oraret_core.sv
// Purpose: Executes the OR forms, the three return forms, call and no-operation.
// Assumes: One decoded instruction offered per start pulse; memory read data valid with it.
// Notes:   Returns take three cycles from start to done because the stack read data is registered.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: Accumulator OR memory byte goes to accumulator; zero flag follows result.
// RULE2: Accumulator OR immediate goes to accumulator; zero flag follows result.
// RULE3: Memory OR accumulator goes to memory; accumulator kept; zero flag updated.
// RULE4: Plain return pops program counter, resumes there, touches no flags.
// RULE5: Return with immediate pops program counter, loads immediate into accumulator.
// RULE6: Interrupt return with no interrupt pending pops program counter and sets master interrupt enable.
// RULE7: Pending interrupt at interrupt return is serviced before the main program.
// RULE8: No-operation only advances the program counter.
module oraret_core (
    // Clock and reset.
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Decoded instruction.
    input  wire logic                           start,
    input  wire logic [oraret_pkg::OP_W-1:0]    op,
    input  wire logic [oraret_pkg::DATA_W-1:0]  imm,
    input  wire logic [oraret_pkg::DATA_W-1:0]  mem_rdata,
    input  wire logic [oraret_pkg::PC_W-1:0]    call_target,
    // Interrupt request.
    input  wire logic                           irq_pending,
    // Memory write.
    output var  logic                           mem_we,
    output var  logic [oraret_pkg::DATA_W-1:0]  mem_wdata,
    // Core state.
    output var  logic [oraret_pkg::DATA_W-1:0]  acc,
    output var  logic                           zero_flag,
    output var  logic [oraret_pkg::PC_W-1:0]    pc,
    output var  logic                           master_interrupt_enable,
    output var  logic                           busy,
    output var  logic                           done
);
    import oraret_pkg::*;

    typedef struct packed {
        oraret_state_t         state;
        logic [OP_W-1:0]       op;
        logic [DATA_W-1:0]     imm;
        logic [DATA_W-1:0]     acc;
        logic                  zero_flag;
        logic [PC_W-1:0]       pc;
        logic                  master_interrupt_enable;
        logic [SP_W-1:0]       sp;
        logic                  mem_we;
        logic [DATA_W-1:0]     mem_wdata;
        logic                  done;
    } oraret_regs_t;

    oraret_regs_t r;
    oraret_regs_t next_r;

    logic            stk_we;
    logic [SP_W-1:0] stk_waddr;
    logic [PC_W-1:0] stk_wdata;
    logic [PC_W-1:0] stk_rdata;
    logic [DATA_W-1:0] or_result;

    function automatic logic is_return(input logic [OP_W-1:0] code);
        return (code == OP_RET) || (code == OP_RET_AX) || (code == OP_INTERRUPT_EXIT_INSTR);
    endfunction

    oraret_stack u_stack (
        .clk     (clk),
        .wr_en   (stk_we),
        .wr_addr (stk_waddr),
        .wr_data (stk_wdata),
        .rd_addr (r.sp - SP_ONE),
        .rd_data (stk_rdata)
    );

    assign or_result = r.acc | (op == OP_OR_AX ? imm : mem_rdata);

    always_comb begin
        next_r    = r;
        next_r.mem_we = 1'b0;
        next_r.done   = 1'b0;
        stk_we    = 1'b0;
        stk_waddr = r.sp;
        stk_wdata = r.pc + PC_ONE;
        case (r.state)
            ORAR_IDLE: begin
                if (start) begin
                    next_r.op  = op;
                    next_r.imm = imm;
                    if (is_return(op)) begin
                        next_r.state = ORAR_EXEC;
                    end else begin
                        next_r.done = 1'b1;
                        next_r.pc   = r.pc + PC_ONE; // [RULE8]
                        case (op)
                            OP_OR_AM, OP_OR_AX: begin
                                next_r.acc       = or_result; // [RULE1] [RULE2]
                                next_r.zero_flag = (or_result == '0); // [RULE1] [RULE2]
                            end
                            OP_ORM: begin
                                next_r.mem_we    = 1'b1; // [RULE3]
                                next_r.mem_wdata = or_result; // [RULE3]
                                next_r.zero_flag = (or_result == '0); // [RULE3]
                            end
                            OP_CALL: begin
                                stk_we    = 1'b1;
                                next_r.sp = r.sp + SP_ONE;
                                next_r.pc = call_target;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            ORAR_EXEC: begin
                next_r.state = ORAR_WAIT;
            end
            ORAR_WAIT: begin
                next_r.state = ORAR_IDLE;
                next_r.done  = 1'b1;
                next_r.sp    = r.sp - SP_ONE;
                next_r.pc    = stk_rdata; // [RULE4]
                if (r.op == OP_RET_AX) begin
                    next_r.acc = r.imm; // [RULE5]
                end
                if (r.op == OP_INTERRUPT_EXIT_INSTR) begin
                    if (irq_pending) begin
                        stk_we    = 1'b1; // [RULE7]
                        stk_waddr = r.sp - SP_ONE;
                        stk_wdata = stk_rdata;
                        next_r.sp = r.sp;
                        next_r.pc = INT_VECTOR; // [RULE7]
                        next_r.master_interrupt_enable = 1'b0;
                    end else begin
                        next_r.master_interrupt_enable = 1'b1; // [RULE6]
                    end
                end
            end
            default: begin
                next_r.state = ORAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r.state     <= ORAR_IDLE;
            r.op        <= OP_NOP;
            r.imm       <= ACC_RESET;
            r.acc       <= ACC_RESET;
            r.zero_flag <= 1'b0;
            r.pc        <= PC_RESET;
            r.master_interrupt_enable <= 1'b0;
            r.sp        <= SP_RESET;
            r.mem_we    <= 1'b0;
            r.mem_wdata <= ACC_RESET;
            r.done      <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_r.state != ORAR_IDLE);
        end
    end

    assign mem_we    = r.mem_we;
    assign mem_wdata = r.mem_wdata;
    assign acc       = r.acc;
    assign zero_flag = r.zero_flag;
    assign pc        = r.pc;
    assign master_interrupt_enable = r.master_interrupt_enable;
    assign done      = r.done;
endmodule // oraret_core
`default_nettype wire

// ### testbench/oraret_core_sva.sv
// Purpose: Checker for the OR and return execution block.
// Assumes: Requests are made only while busy is low.
// Notes:   Bound to every oraret_core instance.
`timescale 1ns/10ps
`default_nettype none
module oraret_core_sva import oraret_pkg::*; (
    input wire logic              clk, rst, start, irq_pending,
    input wire logic [OP_W-1:0]   op,
    input wire logic [DATA_W-1:0] imm, mem_rdata,
    input wire logic [PC_W-1:0]   call_target,
    input wire logic              mem_we, zero_flag, master_interrupt_enable, busy, done,
    input wire logic [DATA_W-1:0] mem_wdata, acc,
    input wire logic [PC_W-1:0]   pc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_OR_MEM: assert property (start && op == OP_OR_AM |=> done && acc == ($past(acc) | $past(mem_rdata))
        && zero_flag == (acc == ACC_RESET)) else $error("or with memory wrong");
    AST_OR_IMM: assert property (start && op == OP_OR_AX |=> acc == ($past(acc) | $past(imm))
        && zero_flag == (acc == ACC_RESET)) else $error("or with immediate wrong");
    AST_OR_STORE: assert property (start && op == OP_ORM |=> mem_we && $stable(acc)
        && mem_wdata == ($past(acc) | $past(mem_rdata))) else $error("or to memory wrong");
    AST_WE_CAUSE: assert property (mem_we |-> $past(start) && $past(op) == OP_ORM)
        else $error("memory write without cause");
    AST_RET_FLAGS: assert property (start && op == OP_RET |-> ##1 busy ##2 done
        && zero_flag == $past(zero_flag, 3)) else $error("return timing or flags wrong");
    AST_RET_IMM: assert property (start && op == OP_RET_AX |-> ##3 done && acc == $past(imm, 3)
        && zero_flag == $past(zero_flag, 3)) else $error("return with immediate wrong");
    AST_INTERRUPT_EXIT_INSTR_EN: assert property (start && op == OP_INTERRUPT_EXIT_INSTR |-> ##3 done
        && master_interrupt_enable != $past(irq_pending)) else $error("interrupt enable wrong");
    AST_INTERRUPT_EXIT_INSTR_IRQ: assert property (start && op == OP_INTERRUPT_EXIT_INSTR ##3 $past(irq_pending) |-> pc == INT_VECTOR)
        else $error("pending interrupt not taken");
    AST_NOP: assert property (start && op == OP_NOP |=> done && pc == $past(pc) + PC_ONE
        && $stable(acc) && !mem_we) else $error("no-operation changed state");
    C_ORM: cover property (start && op == OP_ORM);
    C_INTERRUPT_EXIT_INSTR_IRQ: cover property (start && op == OP_INTERRUPT_EXIT_INSTR ##3 $past(irq_pending));
    C_RET_AX: cover property (start && op == OP_RET_AX ##3 done);
endmodule // oraret_core_sva
bind oraret_core oraret_core_sva i_sva (.*);
`default_nettype wire

// ### testbench/tb_oraret_core.sv
// Purpose: Self-checking bench for the OR and return execution block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Program counter expectations follow the fixed scenario order.
`timescale 1ns/10ps
`default_nettype none
module tb_oraret_core;
    import oraret_pkg::*;
    logic clk = 0, rst = 1, start = 0, irq_pending = 0, mem_we, zero_flag, mie, busy, done;
    logic [OP_W-1:0]   op = OP_NOP;
    logic [DATA_W-1:0] imm = 8'h00, mem_rdata = 8'h00, mem_wdata, acc;
    logic [PC_W-1:0]   call_target = 13'h0000, pc;
    int n_errors = 0, checks = 0;
    always #2.5 clk = ~clk;
    oraret_core i_dut (.clk(clk), .rst(rst), .start(start), .op(op), .imm(imm), .mem_rdata(mem_rdata),
        .call_target(call_target), .irq_pending(irq_pending), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .acc(acc), .zero_flag(zero_flag), .pc(pc), .master_interrupt_enable(mie), .busy(busy), .done(done));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic run(input logic [OP_W-1:0] o, input logic [DATA_W-1:0] i, m, input logic [PC_W-1:0] t);
        int n;
        @(posedge clk);
        #1 start = 1; op = o; imm = i; mem_rdata = m; call_target = t;
        @(posedge clk);
        #1 start = 0; n = 0;
        chk(busy, (o == OP_RET) || (o == OP_RET_AX) || (o == OP_INTERRUPT_EXIT_INSTR));
        while (done !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1 n++;
        end
        chk(done, 1'b1);
        chk(busy, 1'b0);
    endtask
    task automatic t_or;
        run(OP_OR_AX, 8'h00, 8'h00, 13'h0000); chk(zero_flag, 1'b1); chk(acc, 8'h00);
        run(OP_OR_AM, 8'h00, 8'h5A, 13'h0000); chk(acc, 8'h5A); chk(zero_flag, 1'b0);
        run(OP_OR_AX, 8'h81, 8'h00, 13'h0000); chk(acc, 8'hDB);
        run(OP_ORM, 8'h00, 8'h24, 13'h0000); chk(mem_we, 1'b1); chk(mem_wdata, 8'hFF); chk(acc, 8'hDB);
    endtask
    task automatic t_ret;
        run(OP_CALL, 8'h00, 8'h00, 13'h0100); chk(pc, 13'h0100);
        run(OP_RET, 8'h00, 8'h00, 13'h0000); chk(pc, 13'h0005); chk(zero_flag, 1'b0);
        run(OP_CALL, 8'h00, 8'h00, 13'h0200);
        run(OP_RET_AX, 8'h3C, 8'h00, 13'h0000); chk(pc, 13'h0006); chk(acc, 8'h3C);
    endtask
    task automatic t_interrupt_exit_instr;
        run(OP_CALL, 8'h00, 8'h00, 13'h0300);
        run(OP_INTERRUPT_EXIT_INSTR, 8'h00, 8'h00, 13'h0000); chk(pc, 13'h0007); chk(mie, 1'b1);
        run(OP_CALL, 8'h00, 8'h00, 13'h0300);
        irq_pending = 1;
        run(OP_INTERRUPT_EXIT_INSTR, 8'h00, 8'h00, 13'h0000); chk(pc, INT_VECTOR); chk(mie, 1'b0);
        irq_pending = 0;
        run(OP_RET, 8'h00, 8'h00, 13'h0000); chk(pc, 13'h0008);
    endtask
    task automatic t_nop;
        run(OP_NOP, 8'hFF, 8'hFF, 13'h1FFF); chk(pc, 13'h0009); chk(acc, 8'h3C); chk(mem_we, 1'b0);
        run(4'hF, 8'hFF, 8'hFF, 13'h1FFF); chk(pc, 13'h000A); chk(acc, 8'h3C); chk(mem_we, 1'b0);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        chk(acc, ACC_RESET); chk(pc, PC_RESET);
        t_or();
        t_ret();
        t_interrupt_exit_instr();
        t_nop();
        results();
    end
    initial begin
        #10000;
        n_errors++;
        results();
    end
endmodule // tb_oraret_core
`default_nettype wire
